// file: hdl/scg_suspend_command_gate.v
// Suspend command gate: admits or discards decoded transactions by suspend state.
//
// What this block does
// - Octal status read allowed in erase, check suspend.
// - Octal interrupt config read allowed in check suspend.
// - Word program allowed only in erase suspend.
// - Volatile config reads allowed in program, check suspend.
// - Non-volatile config reads rejected while suspended.
// - ID space entry, read, exit allowed in program, check.
// - SPI status one reads allowed in program, check.
// - SPI status two reads allowed in program, check.
// - SPI ECC status read allowed in program suspend.
// - SPI ECC clear allowed in check suspend.
// - Protection lock reads allowed in every suspend.
// - Combined resume allowed in every suspend.
// - Link CRC read allowed in program, check suspend.
// - Fail flag clear allowed in program, check suspend.
// - Identification reads allowed in every suspend.
// - Further suspend rejected in program, check suspend.
// - Resume ignored when nothing is suspended.
// - Resume restarts program first, then erase.
// - Suspend ignored during whole-chip erase.
// - New erase ignored while anything is suspended.
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_suspend_command_gate (
  clk,
  resetn,
  cmd_valid,
  cmd_code,
  busy_op,
  busy_chip_erase,
  op_done,
  cmd_accept,
  cmd_reject,
  cmd_out,
  suspend_req,
  resume_req,
  resume_op,
  erase_suspended,
  program_suspended,
  dicheck_suspended
);
  input wire clk;
  input wire resetn;
  // One-cycle strobe with the decoded command code.
  input wire cmd_valid;
  input wire [5:0] cmd_code;
  // Operation currently running in the embedded engine.
  input wire [1:0] busy_op;
  input wire busy_chip_erase;
  // Pulse from the engine when the running operation finishes.
  input wire op_done;
  output reg cmd_accept;
  output reg cmd_reject;
  output reg [5:0] cmd_out;
  output reg suspend_req;
  output reg resume_req;
  output reg [2:0] resume_op;
  output reg erase_suspended;
  output reg program_suspended;
  output reg dicheck_suspended;

  // ==========================================================================
  // Suspend state and admission
  // ==========================================================================
  reg [2:0] susp;
  // Operation currently running, captured from busy_op while it is not idle; cleared on op_done, or on suspend when busy_op is idle.
  reg [1:0] running;
  wire admit;
  wire [2:0] pick;
  wire any_susp;
  reg [2:0] next_susp;
  reg [1:0] next_running;
  reg next_accept;
  reg next_suspend;
  reg next_resume;
  reg [2:0] next_resume_op;

  scg_admit_table u_admit (
    .cmd(cmd_code),
    .susp(susp),
    .admit(admit)
  );

  scg_resume_pick u_pick (
    .susp(susp),
    .pick(pick),
    .any(any_susp)
  );

  always @* begin
    next_susp = susp;
    next_running = running;
    next_accept = 1'b0;
    next_suspend = 1'b0;
    next_resume = 1'b0;
    next_resume_op = 3'h0;
    if (op_done) begin
      next_running = `SCG_OP_IDLE;
    end
    if (cmd_valid && admit) begin
      next_accept = 1'b1;
      case (cmd_code)
        `SCG_SPI_SUSPEND: begin
          // A chip erase cannot be suspended, so the request is dropped.
          if (busy_chip_erase) begin
            next_accept = 1'b0;
          end else if (running == `SCG_OP_PROGRAM) begin
            next_susp[`SCG_SUSP_PROGRAM] = 1'b1;
            next_suspend = 1'b1;
            next_running = `SCG_OP_IDLE;
          end else if (running == `SCG_OP_SECTOR_ERASE) begin
            next_susp[`SCG_SUSP_ERASE] = 1'b1;
            next_suspend = 1'b1;
            next_running = `SCG_OP_IDLE;
          end else if (running == `SCG_OP_DICHECK) begin
            next_susp[`SCG_SUSP_DICHECK] = 1'b1;
            next_suspend = 1'b1;
            next_running = `SCG_OP_IDLE;
          end else begin
            next_accept = 1'b0;
          end
        end
        `SCG_SPI_RESUME: begin
          if (!any_susp) begin
            next_accept = 1'b0;
          end else begin
            next_susp = susp & ~pick;
            next_resume = 1'b1;
            next_resume_op = pick;
          end
        end
        default: begin
          next_accept = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      susp <= `SCG_SUSP_RESET;
      running <= `SCG_OP_IDLE;
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_out <= 6'h00;
      suspend_req <= 1'b0;
      resume_req <= 1'b0;
      resume_op <= 3'h0;
      erase_suspended <= 1'b0;
      program_suspended <= 1'b0;
      dicheck_suspended <= 1'b0;
    end else begin
      // A discarded command leaves the suspend state untouched.
      susp <= next_susp;
      if (busy_op != `SCG_OP_IDLE && !op_done) begin
        running <= busy_op;
      end else begin
        running <= next_running;
      end
      cmd_accept <= next_accept;
      cmd_reject <= cmd_valid & ~next_accept;
      cmd_out <= cmd_valid ? cmd_code : 6'h00;
      suspend_req <= next_suspend;
      resume_req <= next_resume;
      resume_op <= next_resume_op;
      erase_suspended <= next_susp[`SCG_SUSP_ERASE];
      program_suspended <= next_susp[`SCG_SUSP_PROGRAM];
      dicheck_suspended <= next_susp[`SCG_SUSP_DICHECK];
    end
  end

endmodule

// file: hdl/scg_regs.vh
// Constants for the suspend command gate: command codes, operation codes, suspend state bits.
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

// ==========================================================================
// Command codes on the 6-bit decoded command bus
// ==========================================================================
`define SCG_CMD_W 6
`define SCG_OCT_STATUS_READ 6'h01
`define SCG_OCT_IRQ_CFG_READ 6'h02
`define SCG_OCT_WORD_PROGRAM 6'h03
`define SCG_OCT_VOL_CFG1_READ 6'h04
`define SCG_OCT_VOL_CFG2_READ 6'h05
`define SCG_OCT_NV_CFG1_READ 6'h06
`define SCG_OCT_NV_CFG2_READ 6'h07
`define SCG_ID_SPACE_ENTRY_A 6'h08
`define SCG_ID_SPACE_ENTRY_B 6'h09
`define SCG_ID_SPACE_READ 6'h0A
`define SCG_ALT_SPACE_EXIT 6'h0B
`define SCG_SPI_STATUS1_READ 6'h10
`define SCG_SPI_STATUS1_ADDR_READ 6'h11
`define SCG_SPI_STATUS2_READ 6'h12
`define SCG_SPI_STATUS2_ADDR_READ 6'h13
`define SCG_SPI_ECC_STATUS_READ 6'h14
`define SCG_SPI_ECC_STATUS_CLEAR 6'h15
`define SCG_SPI_PROT_LOCK_READ 6'h16
`define SCG_SPI_PROT_LOCK_ADDR_READ 6'h17
`define SCG_SPI_RESUME 6'h18
`define SCG_SPI_LINK_CRC_READ 6'h19
`define SCG_SPI_FAIL_FLAGS_CLEAR 6'h1A
`define SCG_SPI_IDENT_READ 6'h1B
`define SCG_SPI_IDENT_ADDR_READ 6'h1C
`define SCG_SPI_SUSPEND 6'h1D
`define SCG_ERASE_SECTOR 6'h20
`define SCG_ERASE_CHIP 6'h21

// ==========================================================================
// Operation codes for the busy operation input
// ==========================================================================
`define SCG_OP_IDLE 2'h0
`define SCG_OP_PROGRAM 2'h1
`define SCG_OP_SECTOR_ERASE 2'h2
`define SCG_OP_DICHECK 2'h3
`define SCG_OP_CHIP_ERASE_W 1

// ==========================================================================
// Suspend state vector bit positions and reset value
// ==========================================================================
`define SCG_SUSP_ERASE 0
`define SCG_SUSP_PROGRAM 1
`define SCG_SUSP_DICHECK 2
`define SCG_SUSP_RESET 3'h0

`endif

// file: hdl/scg_admit_table.v
// Combinational admission table: is a command allowed in the current suspend state.
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_admit_table (
  cmd,
  susp,
  admit
);
  input wire [5:0] cmd;
  input wire [2:0] susp;
  output reg admit;

  reg e;
  reg p;
  reg d;
  reg none;

  // ==========================================================================
  // Table lookup
  // ==========================================================================
  // Where more than one operation is suspended, a command passes only if every
  // suspended operation allows it; blank table cells count as not allowed.
  always @* begin
    e = susp[`SCG_SUSP_ERASE];
    p = susp[`SCG_SUSP_PROGRAM];
    d = susp[`SCG_SUSP_DICHECK];
    none = ~(e | p | d);
    case (cmd)
      `SCG_OCT_STATUS_READ: admit = none | (~p & (e | d));
      `SCG_OCT_IRQ_CFG_READ: admit = none | (d & ~e & ~p);
      `SCG_OCT_WORD_PROGRAM: admit = none | (e & ~p & ~d);
      `SCG_OCT_VOL_CFG1_READ,
      `SCG_OCT_VOL_CFG2_READ: admit = none | (~e & (p | d));
      `SCG_OCT_NV_CFG1_READ,
      `SCG_OCT_NV_CFG2_READ: admit = none;
      `SCG_ID_SPACE_ENTRY_A,
      `SCG_ID_SPACE_ENTRY_B,
      `SCG_ID_SPACE_READ,
      `SCG_ALT_SPACE_EXIT: admit = none | (~e & (p | d));
      `SCG_SPI_STATUS1_READ,
      `SCG_SPI_STATUS1_ADDR_READ: admit = none | (~e & (p | d));
      `SCG_SPI_STATUS2_READ,
      `SCG_SPI_STATUS2_ADDR_READ: admit = none | (~e & (p | d));
      `SCG_SPI_ECC_STATUS_READ: admit = none | (p & ~e & ~d);
      `SCG_SPI_ECC_STATUS_CLEAR: admit = none | (d & ~e & ~p);
      `SCG_SPI_PROT_LOCK_READ,
      `SCG_SPI_PROT_LOCK_ADDR_READ: admit = 1'b1;
      `SCG_SPI_RESUME: admit = 1'b1;
      `SCG_SPI_LINK_CRC_READ: admit = none | (~e & (p | d));
      `SCG_SPI_FAIL_FLAGS_CLEAR: admit = none | (~e & (p | d));
      `SCG_SPI_IDENT_READ,
      `SCG_SPI_IDENT_ADDR_READ: admit = 1'b1;
      `SCG_SPI_SUSPEND: admit = ~(p | d);
      `SCG_ERASE_SECTOR,
      `SCG_ERASE_CHIP: admit = none;
      default: admit = none;
    endcase
  end

endmodule

// file: hdl/scg_resume_pick.v
// Picks which suspended operation a resume restarts.
`timescale 1ns/1ps
`include "scg_regs.vh"

module scg_resume_pick (
  susp,
  pick,
  any
);
  input wire [2:0] susp;
  output reg [2:0] pick;
  output reg any;

  // ==========================================================================
  // Priority: program, then erase, then data integrity check
  // ==========================================================================
  always @* begin
    pick = 3'h0;
    any = |susp;
    if (susp[`SCG_SUSP_PROGRAM]) begin
      pick[`SCG_SUSP_PROGRAM] = 1'b1;
    end else if (susp[`SCG_SUSP_ERASE]) begin
      pick[`SCG_SUSP_ERASE] = 1'b1;
    end else if (susp[`SCG_SUSP_DICHECK]) begin
      pick[`SCG_SUSP_DICHECK] = 1'b1;
    end
  end

endmodule

// file: verif/scg_suspend_command_gate_monitor.sv
// Port checker for the suspend command gate.
`timescale 1ns/1ps
`include "scg_regs.vh"
module scg_suspend_command_gate_monitor (
  input wire clk,
  input wire resetn,
  input wire cmd_valid,
  input wire [5:0] cmd_code,
  input wire busy_chip_erase,
  input wire cmd_accept,
  input wire cmd_reject,
  input wire suspend_req,
  input wire resume_req,
  input wire [2:0] resume_op,
  input wire erase_suspended,
  input wire program_suspended,
  input wire dicheck_suspended
);
  wire [2:0] held = {dicheck_suspended, program_suspended, erase_suspended};
  wire rsm = cmd_valid && cmd_code == `SCG_SPI_RESUME;
  wire sus = cmd_valid && cmd_code == `SCG_SPI_SUSPEND;
  wire ers = cmd_code == `SCG_ERASE_SECTOR || cmd_code == `SCG_ERASE_CHIP;
  wire idr = cmd_code == `SCG_SPI_IDENT_READ || cmd_code == `SCG_SPI_IDENT_ADDR_READ;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Properties
  property p_answer;
    cmd_valid |=> cmd_accept ^ cmd_reject;
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_keep;
    cmd_valid ##1 cmd_reject |-> held == $past(held) && !suspend_req && !resume_req;
  endproperty
  a_keep: assert property (p_keep) else $error("reject changed state");
  property p_nores;
    rsm && held == 3'h0 |=> cmd_reject;
  endproperty
  a_nores: assert property (p_nores) else $error("idle resume taken");
  property p_pfirst;
    rsm && program_suspended |=> resume_req && resume_op == 3'h2;
  endproperty
  a_pfirst: assert property (p_pfirst) else $error("program not resumed first");
  property p_eafter;
    rsm && held == 3'h1 |=> resume_op == 3'h1 && held == 3'h0;
  endproperty
  a_eafter: assert property (p_eafter) else $error("erase not resumed");
  property p_chip;
    sus && busy_chip_erase |=> cmd_reject;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase suspended");
  property p_noerase;
    cmd_valid && ers && held != 3'h0 |=> cmd_reject;
  endproperty
  a_noerase: assert property (p_noerase) else $error("erase taken in suspend");
  property p_nosus2;
    sus && held[2:1] != 2'h0 |=> cmd_reject;
  endproperty
  a_nosus2: assert property (p_nosus2) else $error("second suspend taken");
  property p_ident;
    cmd_valid && idr && held != 3'h0 |=> cmd_accept;
  endproperty
  a_ident: assert property (p_ident) else $error("ident read refused");
  c_resume: cover property (resume_req && resume_op == 3'h1);
  c_reject: cover property (cmd_reject && held != 3'h0);
  c_suspend: cover property (suspend_req);
endmodule

// file: verif/scg_host.sv
// Host controller model that issues decoded commands.
`timescale 1ns/1ps
module scg_host (
  input wire clk,
  output reg cmd_valid,
  output reg [5:0] cmd_code
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 6'h00;
  end
  // The code is not held after its strobe; flipping it exposes a late sample.
  task send(input [5:0] code);
    begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code = ~code;
    end
  endtask
endmodule

// file: verif/scg_suspend_command_gate_tb_top.sv
// Self-checking bench for the suspend command gate.
`timescale 1ns/1ps
`include "scg_regs.vh"
module scg_suspend_command_gate_tb_top;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [1:0] busy_op = 2'h0;
  reg busy_chip_erase = 1'b0;
  reg op_done = 1'b0;
  wire cmd_valid, cmd_accept, cmd_reject, suspend_req, resume_req;
  wire erase_suspended, program_suspended, dicheck_suspended;
  wire [5:0] cmd_code, cmd_out;
  wire [2:0] resume_op;
  integer error_cnt = 0;
  integer n_checks = 0;
  scg_suspend_command_gate dut (.*);
  scg_host host (.*);
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task issue(input [5:0] c, input a);
    begin
      host.send(c);
      check({6'h00, cmd_accept, cmd_reject}, {6'h00, a, ~a});
    end
  endtask
  task sweep(input [143:0] l, input a);
    integer i;
    begin
      for (i = 0; i < 24; i = i + 1) begin
        if (l[6*i+:6] !== 6'h00) issue(l[6*i+:6], a);
      end
    end
  endtask
  task flags(input [2:0] e);
    check({5'h00, dicheck_suspended, program_suspended, erase_suspended}, {5'h00, e});
  endtask
  task enter(input [1:0] op);
    begin
      busy_op = op;
      issue(`SCG_SPI_SUSPEND, 1'b1);
      busy_op = 2'h0;
      check({7'h00, suspend_req}, 8'h01);
    end
  endtask
  task resume(input [2:0] op);
    begin
      issue(`SCG_SPI_RESUME, 1'b1);
      check({4'h0, resume_req, resume_op}, {4'h0, 1'b1, op});
    end
  endtask
  // ==========================================================================
  // Scenarios
  task s_prog;
    begin
      enter(`SCG_OP_PROGRAM);
      flags(3'h2);
      sweep({6'h04, 6'h05, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h10, 6'h11, 6'h12, 6'h13,
        6'h14, 6'h16, 6'h17, 6'h19, 6'h1A, 6'h1B, 6'h1C}, 1'b1);
      sweep({6'h03, 6'h06, 6'h07, 6'h1D, 6'h20, 6'h21}, 1'b0);
      flags(3'h2);
      resume(3'h2);
      flags(3'h0);
    end
  endtask
  task s_check;
    begin
      enter(`SCG_OP_DICHECK);
      flags(3'h4);
      sweep({6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h10, 6'h11,
        6'h12, 6'h13, 6'h15, 6'h16, 6'h17, 6'h19, 6'h1A, 6'h1B, 6'h1C}, 1'b1);
      sweep({6'h03, 6'h06, 6'h07, 6'h1D, 6'h20, 6'h21}, 1'b0);
      flags(3'h4);
      resume(3'h4);
    end
  endtask
  task s_erase;
    begin
      enter(`SCG_OP_SECTOR_ERASE);
      flags(3'h1);
      sweep({6'h01, 6'h03, 6'h16, 6'h17, 6'h1B, 6'h1C}, 1'b1);
      sweep({6'h20, 6'h21}, 1'b0);
      enter(`SCG_OP_PROGRAM);
      flags(3'h3);
      resume(3'h2);
      flags(3'h1);
      resume(3'h1);
      flags(3'h0);
    end
  endtask
  task s_misc;
    begin
      issue(`SCG_SPI_RESUME, 1'b0);
      busy_op = `SCG_OP_SECTOR_ERASE;
      busy_chip_erase = 1'b1;
      issue(`SCG_SPI_SUSPEND, 1'b0);
      flags(3'h0);
      busy_chip_erase = 1'b0;
      busy_op = `SCG_OP_IDLE;
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    flags(3'h0);
    s_prog;
    s_check;
    s_erase;
    s_misc;
    conclude;
  end
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    conclude;
  end
endmodule
bind scg_suspend_command_gate scg_suspend_command_gate_monitor mon (.*);
